// ==== rtl/hbfp_map.svh ====
// Address map, reset values and fixed counts of the half-bridge protection block.
// Assumes a 32-bit AXI4-Lite register bus with a 4-bit byte address.
`ifndef HBFP_MAP_SVH
`define HBFP_MAP_SVH
`define HBFP_NB        3
`define HBFP_ADDR_W    4
`define HBFP_OFF_STAT  4'h0
`define HBFP_OFF_MASK  4'h4
`define HBFP_OFF_STATE 4'h8
`define HBFP_RST_STAT  7'h00
`define HBFP_RST_MASK  7'h00
`define HBFP_RESP_OK   2'h0
`define HBFP_RESP_ERR  2'h2
`define HBFP_MODE_PCL  1'h0
`endif

// ==== rtl/hbfp_pkg.sv ====
// Types shared by the half-bridge protection block.
// Assumes hbfp_map.svh is on the include path.
`include "hbfp_map.svh"
package hbfp_pkg;
  // Per-cycle limit state of one half-bridge
  typedef enum logic [1:0] {
    LIM_NONE = 2'b00,
    LIM_HS   = 2'b01,
    LIM_LS   = 2'b10
  } hbfp_lim_t;
  // Gate commands of one half-bridge
  typedef struct packed {
    logic hs_on;
    logic ls_on;
    logic hiz;
  } hbfp_drive_t;
  // Synchronised pin levels of one half-bridge
  typedef struct packed {
    logic oc_short;
    logic oc_low;
    logic oc_high;
    logic rst_n;
    logic pwm;
  } hbfp_sense_t;
  // Sticky event layout, shared by status and mask
  typedef struct packed {
    logic [`HBFP_NB-1:0] shut_set;
    logic                limit;
    logic                uv;
    logic                tsd;
    logic                warn;
  } hbfp_evt_t;
  // Live state readback layout
  typedef struct packed {
    logic [`HBFP_NB-1:0] hiz;
    logic [`HBFP_NB-1:0] shut;
    logic                mode;
    logic                por;
    logic                uv;
    logic                tsd;
    logic                warn;
  } hbfp_state_t;
endpackage

// ==== rtl/hbfp_sync.sv ====
// Two-stage synchroniser for asynchronous pin levels.
// Assumes inputs are slow levels; a pulse shorter than one clock can be lost.
`timescale 1ns/1ps
module hbfp_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else if (ce)
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule

// ==== rtl/hbfp_bridge.sv ====
// One half-bridge: per-cycle limiting, overcurrent shutdown latch, gate commands.
// Assumes synchronised inputs and a common clock and clock enable with the top.
`timescale 1ns/1ps
module hbfp_bridge
  import hbfp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire hbfp_sense_t sense,
  input  wire logic        latch_mode,
  input  wire logic        force_off,
  input  wire logic        por,
  input  wire logic        rst_rise,
  input  wire logic        clear_all,
  output hbfp_drive_t      drive,
  output logic             shut,
  output logic             limit_ev
);
  hbfp_lim_t   lim_q;
  hbfp_lim_t   lim_d;
  hbfp_drive_t drive_q;
  hbfp_drive_t drive_d;
  logic        shut_q;
  logic        shut_d;
  logic        pwm_prev_q;
  logic        limit_ev_q;

  wire pwm_tog  = sense.pwm ^ pwm_prev_q;
  wire shut_set = latch_mode ? (sense.oc_high | sense.oc_low | sense.oc_short)
                             : sense.oc_short; // see RULE16
  wire shut_clr = latch_mode ? clear_all : rst_rise; // see RULE8
  wire off      = force_off | por | !sense.rst_n | shut_d; // see RULE7

  // Limit ends at the next input toggle; a held input keeps it (see RULE17)
  always_comb
  begin
    lim_d = lim_q;
    case (lim_q)
      LIM_NONE: lim_d = LIM_NONE;
      LIM_HS:   if (pwm_tog) lim_d = LIM_NONE;
      LIM_LS:   if (pwm_tog) lim_d = LIM_NONE;
      default:  lim_d = LIM_NONE;
    endcase
    if (!latch_mode && sense.oc_low)
      lim_d = LIM_LS; // see RULE15
    else if (!latch_mode && sense.oc_high && lim_d != LIM_LS)
      lim_d = LIM_HS; // see RULE15
  end

  // Power-on reset dominates, then a new trip beats a clear
  assign shut_d = por ? 1'b0 : shut_set ? 1'b1 : shut_clr ? 1'b0 : shut_q; // see RULE4

  // Gate command; hiz means both FETs off
  always_comb
  begin
    drive_d = '{hs_on: sense.pwm, ls_on: !sense.pwm, hiz: 1'b0};
    if (off)
      drive_d = '{hs_on: 1'b0, ls_on: 1'b0, hiz: 1'b1};
    else if (lim_d == LIM_HS)
      drive_d = '{hs_on: 1'b0, ls_on: 1'b1, hiz: 1'b0}; // see RULE15
    else if (lim_d == LIM_LS)
      drive_d = '{hs_on: 1'b0, ls_on: 1'b0, hiz: 1'b1}; // see RULE15
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lim_q      <= LIM_NONE;
      shut_q     <= 1'b0;
      pwm_prev_q <= 1'b0;
      limit_ev_q <= 1'b0;
      drive_q    <= '{hs_on: 1'b0, ls_on: 1'b0, hiz: 1'b1};
    end
    else if (ce)
    begin
      lim_q      <= lim_d;
      shut_q     <= shut_d;
      pwm_prev_q <= sense.pwm;
      limit_ev_q <= (lim_d != LIM_NONE) && (lim_q == LIM_NONE);
      drive_q    <= drive_d;
    end
  end

  assign drive    = drive_q;
  assign shut     = shut_q;
  assign limit_ev = limit_ev_q;

  property p_hs_limit;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (!latch_mode && sense.oc_high && !sense.oc_low && lim_q != LIM_LS) |=> lim_q == LIM_HS;
  endproperty
  a_hs_limit: assert property (p_hs_limit) else $error("high-side trip did not limit"); // see RULE15

  property p_hold_ls;
    @(posedge aclk) disable iff (!aresetn || !ce)
    (lim_q == LIM_LS && !pwm_tog && !latch_mode) |=> lim_q == LIM_LS && drive_q.hiz;
  endproperty
  a_hold_ls: assert property (p_hold_ls) else $error("low-side limit left without toggle"); // see RULE17
endmodule

// ==== rtl/hbfp_protect.sv ====
// Fault protection and reset control for a three half-bridge power stage,
// with sticky event status, interrupt and AXI4-Lite register access.
// Assumes comparator conditions and controller pins arrive asynchronously.
`timescale 1ns/1ps
`include "hbfp_map.svh"

// Contract
// RULE1: Overheat warning output goes low while the temperature warning condition holds.
// RULE2: Thermal shutdown forces every half-bridge to high impedance and pulls fault low.
// RULE3: Thermal shutdown is latched; only the reset inputs clear it.
// RULE4: Power-on reset clears overcurrent latches and keeps the bridges inactive.
// RULE5: Any supply undervoltage at once forces all bridges off and fault low.
// RULE6: Undervoltage does not latch; operation resumes when supplies return.
// RULE7: Each half-bridge reset input held low keeps both its FETs off.
// RULE8: Per-cycle mode: own reset rising edge clears that bridge's shutdown and fault.
// RULE9: Thermal or latching-mode shutdown clears after all three resets rose.
// RULE10: Two overcurrent modes exist: per-cycle limiting and latching shutdown.
// RULE11: Mode select low chooses per-cycle current limiting.
// RULE12: Controller gives every bridge a short low-side pulse each period.
// RULE13: Controller switches each phase complementarily.
// RULE14: Two-quadrant use with a held low side should pick latching mode.
// RULE15: Per-cycle: high-side trip turns on low side; low-side trip turns both off.
// RULE16: Latching mode disables limiting; any overcurrent shuts the bridge down.
// RULE17: Per-cycle: a held input keeps the bridge off until it toggles.
// RULE18: Fault and warning outputs together encode the device status.
// RULE19: Fault is undervoltage OR thermal latch OR any bridge shutdown latch.
module hbfp_protect
  import hbfp_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  input  wire logic                    temp_warn,
  input  wire logic                    temp_shutdown,
  input  wire logic                    supply_low,
  input  wire logic                    power_on_reset,
  input  wire logic                    overcurrent_mode_select,
  input  wire logic [`HBFP_NB-1:0]     pwm_in,
  input  wire logic [`HBFP_NB-1:0]     bridge_reset_n,
  input  wire logic [`HBFP_NB-1:0]     oc_high,
  input  wire logic [`HBFP_NB-1:0]     oc_low,
  input  wire logic [`HBFP_NB-1:0]     oc_short,
  output logic      [`HBFP_NB-1:0]     hs_on,
  output logic      [`HBFP_NB-1:0]     ls_on,
  output logic      [`HBFP_NB-1:0]     hiz_force,
  output logic                         fault_n,
  output logic                         overheat_warning_n,
  output logic                         irq,
  input  wire logic [`HBFP_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic      [1:0]              s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`HBFP_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic      [31:0]             s_axi_rdata,
  output logic      [1:0]              s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  localparam int NB = `HBFP_NB;
  localparam int SW = 5 + 5 * NB;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [SW-1:0] sync_s;
  logic          warn_s;
  logic          tsd_s;
  logic          uv_s;
  logic          por_s;
  logic          mode_s;
  logic [NB-1:0] pwm_s;
  logic [NB-1:0] rstn_s;
  logic [NB-1:0] och_s;
  logic [NB-1:0] ocl_s;
  logic [NB-1:0] ocs_s;

  hbfp_sync #(.W(SW)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({oc_short, oc_low, oc_high, bridge_reset_n, pwm_in,
                overcurrent_mode_select, power_on_reset, supply_low,
                temp_shutdown, temp_warn}),
    .q       (sync_s)
  );

  // Unpack the synchronised vector
  assign {ocs_s, ocl_s, och_s, rstn_s, pwm_s, mode_s, por_s, uv_s, tsd_s, warn_s} = sync_s;

  // ****************************************************************
  // Shutdown latches and reset tracking
  // ****************************************************************
  logic          tsd_latch_q;
  logic [NB-1:0] rstn_prev_q;
  logic [NB-1:0] seen_q;
  logic [NB-1:0] shut;
  logic [NB-1:0] limit_ev;
  logic [NB-1:0] shut_prev_q;
  logic          uv_prev_q;
  logic          warn_prev_q;
  hbfp_drive_t   drive [NB];

  // Mode pin low selects per-cycle limiting, high selects latching
  wire           latch_mode = (mode_s != `HBFP_MODE_PCL); // see RULE10, see RULE11
  wire [NB-1:0]  rst_rise   = rstn_s & ~rstn_prev_q;
  // Shutdowns that need all three resets to rise before they clear
  wire           global_hold = tsd_latch_q | (latch_mode & (|shut));
  wire           clear_all   = global_hold & (&seen_q); // see RULE9
  // Undervoltage is level driven so recovery needs no reset
  wire           force_off   = uv_s | tsd_s | tsd_latch_q; // see RULE2, see RULE5, see RULE6

  // Thermal latch: a live condition beats the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tsd_latch_q <= 1'b0;
    else if (ce)
      tsd_latch_q <= tsd_s | (tsd_latch_q & !clear_all); // see RULE3
  end

  // Resets that rose while a shutdown is held; earlier edges do not count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rstn_prev_q <= '0;
      seen_q      <= '0;
    end
    else if (ce)
    begin
      rstn_prev_q <= rstn_s;
      seen_q      <= (global_hold && !clear_all) ? (seen_q | rst_rise) : '0; // see RULE9
    end
  end

  // One channel per half-bridge
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++)
    begin : g_br
      hbfp_bridge u_br (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .sense      ('{oc_short: ocs_s[gi], oc_low: ocl_s[gi], oc_high: och_s[gi],
                       rst_n: rstn_s[gi], pwm: pwm_s[gi]}),
        .latch_mode (latch_mode),
        .force_off  (force_off),
        .por        (por_s),
        .rst_rise   (rst_rise[gi]),
        .clear_all  (clear_all),
        .drive      (drive[gi]),
        .shut       (shut[gi]),
        .limit_ev   (limit_ev[gi])
      );
      assign hs_on[gi]     = drive[gi].hs_on;
      assign ls_on[gi]     = drive[gi].ls_on;
      assign hiz_force[gi] = drive[gi].hiz;
    end
  endgenerate

  // ****************************************************************
  // Status pins
  // ****************************************************************
  logic fault_n_q;
  logic warn_n_q;

  // Two pins together give the four status codes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_n_q <= 1'b1;
      warn_n_q  <= 1'b1;
    end
    else if (ce)
    begin
      fault_n_q <= !(uv_s | tsd_latch_q | (|shut)); // see RULE19, see RULE18
      warn_n_q  <= !warn_s; // see RULE1, see RULE18
    end
  end

  assign fault_n            = fault_n_q;
  assign overheat_warning_n = warn_n_q;

  // ****************************************************************
  // Events, status and interrupt
  // ****************************************************************
  hbfp_evt_t stat_q;
  hbfp_evt_t mask_q;
  hbfp_evt_t evt;
  hbfp_evt_t w1c;
  logic      irq_q;

  assign evt = '{shut_set: shut & ~shut_prev_q, limit: |limit_ev,
                 uv: uv_s & !uv_prev_q, tsd: tsd_s & !tsd_latch_q,
                 warn: warn_s & !warn_prev_q};

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        awready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  wire                    wr_go    = s_axi_awvalid & s_axi_wvalid & !awready_q & !bvalid_q;
  wire                    rd_go    = s_axi_arvalid & !arready_q & !rvalid_q;
  wire [`HBFP_ADDR_W-1:0] wa       = {s_axi_awaddr[`HBFP_ADDR_W-1:2], 2'b00};
  wire [`HBFP_ADDR_W-1:0] ra       = {s_axi_araddr[`HBFP_ADDR_W-1:2], 2'b00};
  wire                    wr_stat  = wr_go & s_axi_wstrb[0] & (wa == `HBFP_OFF_STAT);
  wire                    wr_mask  = wr_go & s_axi_wstrb[0] & (wa == `HBFP_OFF_MASK);
  wire                    wr_map   = (wa == `HBFP_OFF_STAT) | (wa == `HBFP_OFF_MASK) |
                                     (wa == `HBFP_OFF_STATE);
  wire                    rd_map   = (ra == `HBFP_OFF_STAT) | (ra == `HBFP_OFF_MASK) |
                                     (ra == `HBFP_OFF_STATE);
  wire hbfp_state_t       live     = '{hiz: hiz_force, shut: shut, mode: mode_s, por: por_s,
                                       uv: uv_s, tsd: tsd_latch_q, warn: warn_s};
  wire [31:0]             rd_word  = (ra == `HBFP_OFF_STAT) ? 32'(stat_q) :
                                     (ra == `HBFP_OFF_MASK) ? 32'(mask_q) :
                                     (ra == `HBFP_OFF_STATE) ? 32'(live) : 32'h0000_0000;

  assign w1c = wr_stat ? hbfp_evt_t'(s_axi_wdata[$bits(hbfp_evt_t)-1:0]) : '0;

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q      <= `HBFP_RST_STAT;
      mask_q      <= `HBFP_RST_MASK;
      irq_q       <= 1'b0;
      shut_prev_q <= '0;
      uv_prev_q   <= 1'b0;
      warn_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      stat_q      <= (stat_q & ~w1c) | evt;
      if (wr_mask)
        mask_q    <= hbfp_evt_t'(s_axi_wdata[$bits(hbfp_evt_t)-1:0]);
      irq_q       <= |(stat_q & mask_q);
      shut_prev_q <= shut;
      uv_prev_q   <= uv_s;
      warn_prev_q <= warn_s;
    end
  end

  // Write path: address and data taken together, response one cycle later
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `HBFP_RESP_OK;
    end
    else if (ce)
    begin
      awready_q <= wr_go;
      if (wr_go)
        bresp_q <= wr_map ? `HBFP_RESP_OK : `HBFP_RESP_ERR;
      if (awready_q)
        bvalid_q <= 1'b1;
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read path: data captured at acceptance, shown after the handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `HBFP_RESP_OK;
      rdata_q   <= 32'h0000_0000;
    end
    else if (ce)
    begin
      arready_q <= rd_go;
      if (rd_go)
      begin
        rdata_q <= rd_word;
        rresp_q <= rd_map ? `HBFP_RESP_OK : `HBFP_RESP_ERR;
      end
      if (arready_q)
        rvalid_q <= 1'b1;
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  assign irq           = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  property p_warn;
    warn_s |=> !overheat_warning_n;
  endproperty
  a_warn: assert property (p_warn) else $error("warning pin not low"); // see RULE1

  property p_tsd_off;
    tsd_s |=> (hiz_force == '1) ##1 !fault_n;
  endproperty
  a_tsd_off: assert property (p_tsd_off) else $error("thermal shutdown not applied"); // see RULE2

  property p_tsd_hold;
    (tsd_latch_q && !(&seen_q)) |=> tsd_latch_q;
  endproperty
  a_tsd_hold: assert property (p_tsd_hold) else $error("thermal latch dropped early"); // see RULE3

  property p_por;
    por_s |=> (shut == '0) && (hiz_force == '1);
  endproperty
  a_por: assert property (p_por) else $error("power-on reset left bridges active"); // see RULE4

  property p_uv;
    uv_s |=> (hiz_force == '1) && !fault_n;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not applied"); // see RULE5

  property p_uv_free;
    (!uv_s && !tsd_latch_q && shut == '0) |=> fault_n;
  endproperty
  a_uv_free: assert property (p_uv_free) else $error("fault held without cause"); // see RULE6

  property p_rst_off;
    !rstn_s[0] |=> hiz_force[0] && !hs_on[0] && !ls_on[0];
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("reset low left bridge on"); // see RULE7

  property p_pcl_clear;
    (!latch_mode && shut[2] && rst_rise[2] && !ocs_s[2] && !por_s) |=> !shut[2];
  endproperty
  a_pcl_clear: assert property (p_pcl_clear) else $error("own reset did not clear"); // see RULE8

  property p_all_clear;
    (tsd_latch_q && !tsd_s && (&seen_q)) |=> !tsd_latch_q;
  endproperty
  a_all_clear: assert property (p_all_clear) else $error("thermal latch not cleared"); // see RULE9

  property p_latch_trip;
    (latch_mode && och_s[1] && !por_s) |=> shut[1] ##1 !fault_n;
  endproperty
  a_latch_trip: assert property (p_latch_trip) else $error("latching trip missed"); // see RULE16

  property p_fault_or;
    fault_n != $past(uv_s | tsd_latch_q | (|shut));
  endproperty
  a_fault_or: assert property (p_fault_or) else $error("fault pin mismatch"); // see RULE19

  c_tsd_cycle: cover property (tsd_latch_q ##[1:200] !tsd_latch_q);
  c_pcl_limit: cover property (!latch_mode && |limit_ev);
  c_irq:       cover property ($rose(irq));
  c_rd:        cover property (s_axi_rvalid && s_axi_rready);
endmodule

// ==== verif/hbfp_ctrl.sv ====
// Controller model: PWM and active-low bridge reset pins for the protection block.
// Assumes the bench clock; outputs change only just after rising edges.
`timescale 1ns/1ps
module hbfp_ctrl (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       hold,
  input  wire logic [2:0] level,
  input  wire logic [2:0] rst_req,
  output logic      [2:0] pwm_in,
  output logic      [2:0] bridge_reset_n
);
  logic [3:0] cnt_q;
  // Free run keeps 5 low-side cycles (100 ns) per period so the bootstrap recharges
  always_ff @(posedge aclk)
  begin
    cnt_q          <= aresetn ? cnt_q + 4'h1 : 4'h0;
    pwm_in         <= hold ? level : {3{cnt_q < 4'hB}};
    bridge_reset_n <= ~rst_req;
  end
endmodule

// ==== verif/testbench.sv ====
// Bench for the half-bridge protection block: pins, controller model, AXI4-Lite.
// Assumes hbfp_map.svh on the include path and the controller model compiled first.
`timescale 1ns/1ps
`include "hbfp_map.svh"
module testbench;
  logic        aclk, aresetn, tw, ts, sl, por, mode, hold, awv, wv, arv;
  logic        awr, wr, bv, arr, rv, fn, wn, irq;
  logic [2:0]  lvl, rst_req, oh, ol, osh, pwm, brn, hs, ls, hz;
  logic [3:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  br, rr;
  int          mismatches, comparisons, n;
  // Responses are always accepted, so bready and rready stay high
  hbfp_protect dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .temp_warn(tw), .temp_shutdown(ts),
    .supply_low(sl), .power_on_reset(por), .overcurrent_mode_select(mode), .pwm_in(pwm),
    .bridge_reset_n(brn), .oc_high(oh), .oc_low(ol), .oc_short(osh), .hs_on(hs),
    .ls_on(ls), .hiz_force(hz), .fault_n(fn), .overheat_warning_n(wn), .irq(irq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'h1)
  );
  hbfp_ctrl ctrl (.aclk(aclk), .aresetn(aresetn), .hold(hold), .level(lvl),
    .rst_req(rst_req), .pwm_in(pwm), .bridge_reset_n(brn));
  // 50 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic results(); // Counts, verdict, end of run
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(string name, logic [35:0] s, logic [35:0] e);
    comparisons++;
    if (s !== e) mismatches++;
    if (s !== e) $display("[FAIL] %s expected %h seen %h", name, e, s);
  endtask
  // Reset release reaches fault_n after six edges; eight leave margin. Off bridges drive nothing
  task automatic cp(string name, logic [2:0] z, logic f, logic w);
    repeat (8) @(posedge aclk);
    check(name, 36'({hz, hs, ls, fn, wn}), 36'({z, lvl & ~z, ~lvl & ~z, f, w}));
  endtask
  task automatic pulse(logic [2:0] m); // Resets low, then released together
    rst_req <= m;
    repeat (6) @(posedge aclk);
    rst_req <= 3'h0;
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d); // Each channel dropped when taken
    {awa, wd, awv, wv} <= {a, d, 2'h3};
    for (n = 0; n == 0 || (bv !== 1'b1 && n < 50); n++)
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end
    if (bv !== 1'b1) mismatches++;
    if (bv !== 1'b1) results();
    check("bresp", 36'(br), 36'(`HBFP_RESP_OK));
  endtask
  task automatic rd_chk(string name, logic [3:0] a, logic [31:0] d, logic [1:0] r);
    {ara, arv} <= {a, 1'b1};
    for (n = 0; n == 0 || (rv !== 1'b1 && n < 50); n++)
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end
    if (rv !== 1'b1) mismatches++;
    if (rv !== 1'b1) results();
    check(name, {2'h0, rr, rd}, {2'h0, r, d});
  endtask
  task automatic t_basic(); // Free run, unmapped read, warning, interrupt mask and clear
    repeat (40) @(posedge aclk);
    check("run", 36'({fn, wn}), 36'h3);
    hold <= 1'b1;
    cp("idle", 3'h0, 1'b1, 1'b1);
    rd_chk("unmapped", 4'hC, 32'h0, `HBFP_RESP_ERR);
    tw <= 1'b1;
    cp("warn", 3'h0, 1'b1, 1'b0);
    wr_reg(`HBFP_OFF_MASK, 32'h1);
    rd_chk("mask", `HBFP_OFF_MASK, 32'h1, `HBFP_RESP_OK);
    repeat (6) @(posedge aclk);
    check("irq", 36'(irq), 36'h1);
    wr_reg(`HBFP_OFF_STAT, 32'h1);
    repeat (6) @(posedge aclk);
    check("irq clear", 36'(irq), 36'h0);
    tw <= 1'b0;
  endtask
  task automatic t_tsd(); // Thermal latch outlives the condition and a partial reset
    ts <= 1'b1;
    cp("tsd", 3'h7, 1'b0, 1'b1);
    check("irq masked", 36'(irq), 36'h0);
    rd_chk("stat", `HBFP_OFF_STAT, 32'h2, `HBFP_RESP_OK);
    ts <= 1'b0;
    pulse(3'h3);
    cp("tsd held", 3'h7, 1'b0, 1'b1);
    pulse(3'h7);
    cp("tsd clear", 3'h0, 1'b1, 1'b1);
  endtask
  task automatic t_uv(); // Undervoltage recovers alone; a held reset parks one bridge
    sl <= 1'b1;
    cp("uv", 3'h7, 1'b0, 1'b1);
    sl <= 1'b0;
    cp("uv gone", 3'h0, 1'b1, 1'b1);
    rst_req <= 3'h2;
    cp("bridge off", 3'h2, 1'b1, 1'b1);
    rd_chk("state", `HBFP_OFF_STATE, 32'h200, `HBFP_RESP_OK);
    rst_req <= 3'h0;
  endtask
  task automatic t_cbc(); // Per-cycle limits on both sides, held input, severe trip
    oh <= 3'h1;
    repeat (6) @(posedge aclk);
    check("hs trip", 36'({hz, hs, ls, fn}), 36'h047);
    {oh, lvl} <= {3'h0, 3'h4};
    cp("hs end", 3'h0, 1'b1, 1'b1);
    ol <= 3'h1;
    cp("ls trip", 3'h1, 1'b1, 1'b1);
    ol <= 3'h0;
    cp("held", 3'h1, 1'b1, 1'b1);
    lvl <= 3'h5;
    cp("toggled", 3'h0, 1'b1, 1'b1);
    osh <= 3'h4;
    cp("short", 3'h4, 1'b0, 1'b1);
    osh <= 3'h0;
    pulse(3'h4);
    cp("own reset", 3'h0, 1'b1, 1'b1);
  endtask
  task automatic t_latch(); // Latching mode: own reset is not enough, all three are
    mode <= 1'b1;
    oh <= 3'h2;
    cp("latched", 3'h2, 1'b0, 1'b1);
    oh <= 3'h0;
    pulse(3'h2);
    cp("own only", 3'h2, 1'b0, 1'b1);
    pulse(3'h7);
    cp("all three", 3'h0, 1'b1, 1'b1);
  endtask
  task automatic t_por(); // Power-on reset drops a latched trip without bridge resets
    osh <= 3'h1;
    cp("trip", 3'h1, 1'b0, 1'b1);
    {por, osh} <= 4'h8;
    cp("por", 3'h7, 1'b1, 1'b1);
    por <= 1'b0;
    cp("por done", 3'h0, 1'b1, 1'b1);
  endtask
  // Main sequence: reset for ten cycles, then the scenarios in turn
  initial
  begin
    {aresetn, tw, ts, sl, por, mode, hold, awv, wv, arv} = 10'h0;
    {lvl, rst_req, oh, ol, osh} = 15'h5000;
    {awa, ara, wd} = 40'h0;
    mismatches = 0;
    comparisons = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_basic();
    t_tsd();
    t_uv();
    t_cbc();
    t_latch();
    t_por();
    results();
  end
endmodule
